/* File: phy_basic_control_low_bits.sv */
// basic mode control low bits with serial management access and isolation gating
`timescale 1ns/100ps
`default_nettype none
`include "phy_ctrl_params.svh"
// Functional notes
// - isolate ignores transmit inputs, tri-states MII outputs
// - management and reference clock stay alive isolated
// - isolated: idle on tp, tri-state others, link off
// - reset sets isolate only for address 00000
// - write one restarts negotiation, needs enable bit
// - restart reads one until negotiation starts
// - software clearing restart leaves negotiation running
// - duplex bit forces full/half, resets to one
// - duplex reads control value, not actual status
// - collision test echoes transmit enable onto collision
// - reserved bits written zero, read value meaningless
// - negotiation enable overrides forced duplex and speed
module phy_basic_control_low_bits (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [4:0] phy_address_strap,
  input wire logic [4:0] ctrl_upper_bits,
  input wire logic an_enable,
  input wire logic speed_select,
  input wire logic an_started,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [3:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  output logic [3:0] core_txd,
  output logic core_tx_en,
  output logic core_tx_er,
  input wire logic core_tx_clk,
  input wire logic core_rx_clk,
  input wire logic core_rx_dv,
  input wire logic core_rx_er,
  input wire logic [3:0] core_rxd,
  input wire logic core_col,
  input wire logic core_crs,
  output logic tx_clk,
  output logic rx_clk,
  output logic rx_dv,
  output logic rx_er,
  output logic [3:0] rxd,
  output logic col,
  output logic crs,
  output logic mii_out_oe,
  input wire logic ref_clock_enable,
  input wire logic ref_clock_core,
  output logic ref_clock_out,
  output logic ref_clock_oe,
  output logic tp_send_idle,
  output logic ten_transmit_oe,
  output logic media_rx_ignore,
  output logic link_disable,
  output logic an_restart_req,
  output logic forced_mode_valid,
  output logic forced_full_duplex,
  output logic forced_speed_100,
  output logic [15:0] control_value
);
  // ============================================================
  // control bits
  logic isolate;
  logic restart;
  logic duplex;
  logic coll_test;
  logic [4:0] phy_addr;

  // ============================================================
  // management frame state
  phy_ctrl_pkg::mgmt_state_e state;
  phy_ctrl_pkg::mgmt_state_e next_state;
  logic mdc_q;
  logic [5:0] pre_cnt;
  logic [3:0] bit_cnt;
  logic [12:0] hdr;
  logic [15:0] wr_shift;
  logic [15:0] rd_shift;
  logic hit_read;
  logic hit_write;

  function automatic logic [15:0] pack_value(input logic [4:0] upper, input logic iso,
                                             input logic rst_an, input logic dpx,
                                             input logic ct);
    pack_value = {upper, iso, rst_an, dpx, ct, {`BMC_RSVD_WIDTH{1'b0}}};
  endfunction

  // ============================================================
  // decode
  // mdc is oversampled, so each of its edges shows as a one-cycle pulse
  wire mdc_rise = mdc & ~mdc_q;
  wire mdc_fall = ~mdc & mdc_q;
  wire rise_hdr = mdc_rise && (state == phy_ctrl_pkg::MG_HDR);
  wire rise_ta = mdc_rise && (state == phy_ctrl_pkg::MG_TA);
  wire rise_data = mdc_rise && (state == phy_ctrl_pkg::MG_DATA);
  wire [12:0] next_hdr = {hdr[11:0], mdio_in};
  wire hdr_start = next_hdr[`MGMT_HDR_START];
  wire [1:0] hdr_op = next_hdr[`MGMT_OP_MSB:`MGMT_OP_LSB];
  wire [4:0] hdr_phy = next_hdr[`MGMT_PHY_MSB:`MGMT_PHY_LSB];
  wire [4:0] hdr_reg = next_hdr[`MGMT_REG_MSB:`MGMT_REG_LSB];
  // reserved bits read as zero; software must not rely on them
  wire [15:0] read_value = pack_value(ctrl_upper_bits, isolate, restart, duplex, coll_test);
  wire hdr_done = rise_hdr && (bit_cnt == `MGMT_HDR_LAST);
  // a frame for another address or register passes by with no answer
  wire hdr_match = hdr_start && (hdr_phy == phy_addr) && (hdr_reg == `BMC_REG_ADDR);
  wire op_read = (hdr_op == `MGMT_OP_READ);
  wire op_write = (hdr_op == `MGMT_OP_WRITE);
  wire ta_done = rise_ta && (bit_cnt == `MGMT_TA_LAST);
  wire data_done = rise_data && (bit_cnt == `MGMT_DATA_LAST);
  wire [15:0] wr_word = {wr_shift[14:0], mdio_in};
  wire commit = data_done && hit_write;
  // restart only takes when negotiation is enabled
  wire restart_set = commit && wr_word[`BMC_RESTART_BIT] && an_enable;
  // software clear only drops the request, running negotiation untouched
  wire restart_clr = (commit && !wr_word[`BMC_RESTART_BIT]) || an_started;
  wire pre_full = (pre_cnt == `MGMT_PRE_LEN);
  // the line turns around in the second turnaround bit and carries data after it
  wire drive_ta = (state == phy_ctrl_pkg::MG_TA) && (bit_cnt == `MGMT_TA_LAST) && hit_read;
  wire drive_data = (state == phy_ctrl_pkg::MG_DATA) && hit_read;
  wire start_seen = mdc_rise && !mdio_in && pre_full;

  always_comb begin
    next_state = state;
    case (state)
      phy_ctrl_pkg::MG_PRE: begin
        if (start_seen) begin
          next_state = phy_ctrl_pkg::MG_HDR;
        end
      end
      phy_ctrl_pkg::MG_HDR: begin
        if (hdr_done) begin
          next_state = phy_ctrl_pkg::MG_TA;
        end
      end
      phy_ctrl_pkg::MG_TA: begin
        if (ta_done) begin
          next_state = phy_ctrl_pkg::MG_DATA;
        end
      end
      phy_ctrl_pkg::MG_DATA: begin
        if (data_done) begin
          next_state = phy_ctrl_pkg::MG_PRE;
        end
      end
      default: next_state = phy_ctrl_pkg::MG_PRE;
    endcase
  end

  // ============================================================
  // management frame engine, alive even while isolated
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= phy_ctrl_pkg::MG_PRE;
      mdc_q <= 1'b0;
    end else begin
      state <= next_state;
      mdc_q <= mdc;
    end
  end

  // preamble ones and bit position within the current field
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pre_cnt <= 6'h00;
      bit_cnt <= 4'h0;
    end else begin
      if (state != phy_ctrl_pkg::MG_PRE) begin
        pre_cnt <= 6'h00;
      end else if (mdc_rise) begin
        if (!mdio_in) begin
          pre_cnt <= 6'h00;
        end else if (!pre_full) begin
          pre_cnt <= pre_cnt + 6'h01;
        end
      end
      if (next_state != state) begin
        bit_cnt <= 4'h0;
      end else if (mdc_rise) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // header and write data shift in on the rising management clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hdr <= 13'h0000;
      wr_shift <= 16'h0000;
      hit_read <= 1'b0;
      hit_write <= 1'b0;
    end else begin
      if (rise_hdr) begin
        hdr <= next_hdr;
      end
      if (hdr_done) begin
        hit_read <= hdr_match && op_read;
        hit_write <= hdr_match && op_write;
      end
      if (rise_data) begin
        wr_shift <= wr_word;
      end
    end
  end

  // the device turns the line around and shifts read data on the falling clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      rd_shift <= 16'h0000;
    end else begin
      if (hdr_done) begin
        rd_shift <= read_value;
      end
      if (mdc_fall) begin
        if (drive_ta) begin
          mdio_oe <= 1'b1;
          mdio_out <= 1'b0;
        end else if (drive_data) begin
          mdio_oe <= 1'b1;
          mdio_out <= rd_shift[15];
          rd_shift <= {rd_shift[14:0], 1'b0};
        end else begin
          mdio_oe <= 1'b0;
          mdio_out <= 1'b0;
        end
      end
    end
  end

  // ============================================================
  // control register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // strap is sampled while reset is held, synchronously
      phy_addr <= phy_address_strap;
      isolate <= (phy_address_strap == `BMC_ISOLATE_ADDR);
      restart <= `BMC_RESTART_RST;
      duplex <= `BMC_DUPLEX_RST;
      coll_test <= `BMC_COLTEST_RST;
    end else begin
      if (commit) begin
        isolate <= wr_word[`BMC_ISOLATE_BIT];
        duplex <= wr_word[`BMC_DUPLEX_BIT];
        coll_test <= wr_word[`BMC_COLTEST_BIT];
      end
      // a new request wins over a start seen in the same cycle
      if (restart_set) begin
        restart <= 1'b1;
      end else if (restart_clr) begin
        restart <= 1'b0;
      end
    end
  end

  // ============================================================
  // MII and media gating; MII signals are registered, output enables and media controls are not
  // transmit inputs are dropped while isolated
  wire [3:0] gated_txd = isolate ? 4'h0 : txd;
  wire gated_tx_en = tx_en & ~isolate;
  wire gated_tx_er = tx_er & ~isolate;
  // col is released while isolated, so the echo there is never seen
  wire col_echo = core_col | (coll_test & tx_en);
  wire ref_clock_gated = ref_clock_core & ref_clock_enable;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      core_txd <= 4'h0;
      core_tx_en <= 1'b0;
      core_tx_er <= 1'b0;
      tx_clk <= 1'b0;
      rx_clk <= 1'b0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      rxd <= 4'h0;
      col <= 1'b0;
      crs <= 1'b0;
      ref_clock_out <= 1'b0;
    end else begin
      core_txd <= gated_txd;
      core_tx_en <= gated_tx_en;
      core_tx_er <= gated_tx_er;
      tx_clk <= core_tx_clk;
      rx_clk <= core_rx_clk;
      rx_dv <= core_rx_dv;
      rx_er <= core_rx_er;
      rxd <= core_rxd;
      col <= col_echo;
      crs <= core_crs;
      ref_clock_out <= ref_clock_gated;
    end
  end

  // outputs are released, not zeroed, so the bus sees high impedance
  assign mii_out_oe = ~isolate;
  assign ref_clock_oe = ref_clock_enable;
  assign tp_send_idle = isolate;
  assign ten_transmit_oe = ~isolate;
  assign media_rx_ignore = isolate;
  assign link_disable = isolate;
  assign an_restart_req = restart & an_enable;
  // forced settings matter only with negotiation off
  assign forced_mode_valid = ~an_enable;
  assign forced_full_duplex = duplex;
  assign forced_speed_100 = speed_select;
  assign control_value = read_value;
endmodule
`default_nettype wire

/* File: phy_ctrl_assertions.sv */
// checker for the control low bits ports
`timescale 1ns/100ps
`default_nettype none
module phy_ctrl_check (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic an_enable,
  input wire logic speed_select,
  input wire logic an_started,
  input wire logic tx_en,
  input wire logic [4:0] phy_address_strap,
  input wire logic [3:0] core_txd,
  input wire logic core_tx_en,
  input wire logic core_tx_er,
  input wire logic col,
  input wire logic mii_out_oe,
  input wire logic ref_clock_enable,
  input wire logic ref_clock_oe,
  input wire logic tp_send_idle,
  input wire logic ten_transmit_oe,
  input wire logic media_rx_ignore,
  input wire logic link_disable,
  input wire logic an_restart_req,
  input wire logic forced_mode_valid,
  input wire logic forced_full_duplex,
  input wire logic forced_speed_100,
  input wire logic mdio_oe,
  input wire logic [15:0] control_value
);
  // ============================================================
  // checks
  wire iso = control_value[10];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  iso_oe_a: assert property (mii_out_oe == !iso) else $error("oe");
  iso_tx_a: assert property (iso && $past(iso) |->
    {core_tx_en, core_tx_er, core_txd} == 6'h00) else $error("tx gate");
  iso_media_a: assert property ({tp_send_idle, link_disable, media_rx_ignore,
    ten_transmit_oe} == {iso, iso, iso, !iso}) else $error("media");
  ref_clk_a: assert property (ref_clock_oe == ref_clock_enable) else $error("ref");
  reset_iso_a: assert property ($rose(rst_n) |-> iso == (phy_address_strap == 5'h00))
    else $error("reset iso");
  restart_req_a: assert property (an_restart_req == (control_value[9] && an_enable))
    else $error("restart req");
  restart_clr_a: assert property (control_value[9] && an_started |=> !control_value[9])
    else $error("restart clear");
  forced_mode_a: assert property ({forced_mode_valid, forced_full_duplex,
    forced_speed_100} == {!an_enable, control_value[8], speed_select}) else $error("forced");
  col_test_a: assert property (control_value[7] && tx_en |=> col) else $error("col");
  rsvd_zero_a: assert property (control_value[6:0] == 7'h00) else $error("rsvd");
  cover property (control_value[7] && tx_en);
  cover property (control_value[9] && an_started);
  cover property (iso && mdio_oe);
endmodule
bind phy_basic_control_low_bits phy_ctrl_check chk (.sys_clk, .rst_n, .an_enable,
  .speed_select, .an_started, .tx_en, .phy_address_strap, .core_txd, .core_tx_en,
  .core_tx_er, .col,
  .mii_out_oe, .ref_clock_enable, .ref_clock_oe, .tp_send_idle, .ten_transmit_oe,
  .media_rx_ignore, .link_disable, .an_restart_req, .forced_mode_valid,
  .forced_full_duplex, .forced_speed_100, .mdio_oe, .control_value);
`default_nettype wire

/* File: phy_ctrl_params.svh */
// register map, field positions, reset values and frame constants of the control low bits
`ifndef PHY_CTRL_PARAMS_SVH
`define PHY_CTRL_PARAMS_SVH
// ============================================================
// register address and field positions
`define BMC_REG_ADDR 5'h00
`define BMC_ISOLATE_BIT 10
`define BMC_RESTART_BIT 9
`define BMC_DUPLEX_BIT 8
`define BMC_COLTEST_BIT 7
`define BMC_UPPER_MSB 15
`define BMC_UPPER_LSB 11
`define BMC_RSVD_WIDTH 7
// ============================================================
// reset values
`define BMC_ISOLATE_ADDR 5'h00
`define BMC_DUPLEX_RST 1'h1
`define BMC_COLTEST_RST 1'h0
`define BMC_RESTART_RST 1'h0
// ============================================================
// management frame
`define MGMT_PRE_LEN 6'h20
`define MGMT_HDR_LAST 4'hC
`define MGMT_TA_LAST 4'h1
`define MGMT_DATA_LAST 4'hF
`define MGMT_OP_READ 2'h2
`define MGMT_OP_WRITE 2'h1
// ============================================================
// management header fields, counted from the start bit down
`define MGMT_HDR_START 12
`define MGMT_OP_MSB 11
`define MGMT_OP_LSB 10
`define MGMT_PHY_MSB 9
`define MGMT_PHY_LSB 5
`define MGMT_REG_MSB 4
`define MGMT_REG_LSB 0
`endif

/* File: phy_ctrl_pkg.sv */
// types shared by the basic mode control low bits
`default_nettype none
package phy_ctrl_pkg;
  // ============================================================
  // management frame states, one-hot
  typedef enum logic [3:0] {
    MG_PRE = 4'h1,
    MG_HDR = 4'h2,
    MG_TA = 4'h4,
    MG_DATA = 4'h8
  } mgmt_state_e;
endpackage
`default_nettype wire

/* File: phy_mgmt_station.sv */
// station manager model sending management frames
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_station (
  input wire logic sys_clk,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdc,
  output logic mdio_line
);
  // ============================================================
  // line and frame
  logic drv;
  // released line sits at the pull-up level, so a silent device reads ones
  assign mdio_line = mdio_oe ? mdio_out : drv;
  initial begin
    mdc = 1'h0;
    drv = 1'h1;
  end
  // mdc idles low between frames; two clocks low and three high per bit suit the sampler
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [15:0] wd,
    output logic [15:0] rd);
    logic [63:0] s;
    s = {32'hFFFFFFFF, 2'h1, op, phy, 5'h00, 2'h2, wd};
    if (op == 2'h2) s[17:0] = 18'h3FFFF;
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(negedge sys_clk);
      mdc = 1'h0;
      drv = s[i];
      repeat (2) @(negedge sys_clk);
      mdc = 1'h1;
      rd = {rd[14:0], mdio_line};
      repeat (2) @(negedge sys_clk);
    end
    @(negedge sys_clk);
    mdc = 1'h0;
    drv = 1'h1;
    repeat (3) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// bench for the control low bits
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ============================================================
  // signals and tasks
  logic sys_clk, rst_n, an_enable, speed_select, an_started, mdc, mdio_in, tx_en, tx_er;
  logic [4:0] phy_address_strap, ctrl_upper_bits;
  logic [3:0] txd, core_txd, core_rxd, rxd;
  logic core_tx_clk, core_rx_clk, core_rx_dv, core_rx_er, core_col, core_crs;
  logic mdio_out, mdio_oe, core_tx_en, core_tx_er, tx_clk, rx_clk, rx_dv, rx_er, col, crs;
  logic mii_out_oe, ref_clock_enable, ref_clock_core, ref_clock_out, ref_clock_oe;
  logic tp_send_idle, ten_transmit_oe, media_rx_ignore, link_disable, an_restart_req;
  logic forced_mode_valid, forced_full_duplex, forced_speed_100;
  logic [15:0] control_value, rdv;
  int error_cnt = 0;
  int total_checks = 0;
  phy_basic_control_low_bits DUT (.sys_clk, .rst_n, .phy_address_strap, .ctrl_upper_bits,
    .an_enable, .speed_select, .an_started, .mdc, .mdio_in, .mdio_out, .mdio_oe, .txd,
    .tx_en, .tx_er, .core_txd, .core_tx_en, .core_tx_er, .core_tx_clk, .core_rx_clk,
    .core_rx_dv, .core_rx_er, .core_rxd, .core_col, .core_crs, .tx_clk, .rx_clk, .rx_dv,
    .rx_er, .rxd, .col, .crs, .mii_out_oe, .ref_clock_enable, .ref_clock_core,
    .ref_clock_out, .ref_clock_oe, .tp_send_idle, .ten_transmit_oe, .media_rx_ignore,
    .link_disable, .an_restart_req, .forced_mode_valid, .forced_full_duplex,
    .forced_speed_100, .control_value);
  phy_mgmt_station stn (.sys_clk, .mdio_out, .mdio_oe, .mdc, .mdio_line(mdio_in));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    stn.frame(2'h1, phy_address_strap, d, rdv);
  endtask
  task automatic rd(input logic [15:0] exp, input string what);
    stn.frame(2'h2, phy_address_strap, 16'h0000, rdv);
    check(what, rdv, exp);
  endtask
  task automatic reset(input logic [4:0] a);
    @(negedge sys_clk);
    phy_address_strap = a;
    rst_n = 1'h0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'h1;
  endtask
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // about fourteen frames of 324 clocks each, with margin
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    {rst_n, an_enable, speed_select, an_started, tx_en, tx_er, core_col} = 7'h00;
    {core_tx_clk, core_rx_clk, core_rx_dv, core_rx_er, core_crs, txd, core_rxd} = 13'h0000;
    {ref_clock_enable, ref_clock_core, ctrl_upper_bits, phy_address_strap} = 12'hEA0;
    reset(5'h00);
    rd(16'hAD00, "reset word");
    {tx_en, tx_er, txd, core_tx_clk, core_rx_clk} = 8'hFF;
    {core_rx_dv, core_rx_er, core_crs, core_rxd} = 7'h7F;
    repeat (2) @(negedge sys_clk);
    check("gated tx", {core_tx_en, core_tx_er, core_txd}, 16'h0000);
    check("iso media", {mii_out_oe, tp_send_idle, link_disable, ten_transmit_oe}, 16'h0006);
    check("ref clock", {ref_clock_out, ref_clock_oe}, 16'h0003);
    ref_clock_enable = 1'h0;
    repeat (2) @(negedge sys_clk);
    check("ref clock off", {ref_clock_out, ref_clock_oe}, 16'h0000);
    ref_clock_enable = 1'h1;
    $display("isolate test done");
    speed_select = 1'h1;
    wr(16'h0000);
    rd(16'hA800, "cleared word");
    check("tx resumes", {core_tx_en, core_txd, rx_dv, rxd}, 16'h03FF);
    check("mii copies", {core_tx_er, tx_clk, rx_clk, rx_er, crs}, 16'h001F);
    check("forced", {forced_mode_valid, forced_full_duplex, forced_speed_100}, 16'h0005);
    wr(16'h0200);
    rd(16'hA800, "restart no an");
    an_enable = 1'h1;
    wr(16'h0300);
    rd(16'hAB00, "restart held");
    check("restart req", {an_restart_req, forced_mode_valid}, 16'h0002);
    wr(16'h0100);
    rd(16'hA900, "restart cleared");
    wr(16'h0200);
    an_started = 1'h1;
    @(negedge sys_clk);
    an_started = 1'h0;
    rd(16'hA800, "self clear");
    $display("restart test done");
    an_enable = 1'h0;
    wr(16'h0080);
    rd(16'hA880, "reserved");
    check("col test", {col, core_col}, 16'h0002);
    tx_en = 1'h0;
    repeat (2) @(negedge sys_clk);
    check("col idle", {15'h0000, col}, 16'h0000);
    reset(5'h03);
    rd(16'hA900, "nonzero address");
    $display("collision and strap test done");
    print_verdict();
  end
endmodule
`default_nettype wire
